/* asp_consts.vh */
// Constants for the asynchronous serial port block.
// Assumes inclusion by bare name from the design file only.
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH

// APB byte addresses
`define ASP_ADDR_CTRL      12'h000
`define ASP_ADDR_BUF       12'h004
`define ASP_ADDR_RELOAD    12'h008
`define ASP_ADDR_TIMER     12'h00C

// Serial control register bit positions
`define ASP_CB_MODE        7
`define ASP_CB_ONE         6
`define ASP_CB_MCE         5
`define ASP_CB_REN         4
`define ASP_CB_TB8         3
`define ASP_CB_RB8         2
`define ASP_CB_TI          1
`define ASP_CB_RI          0

// Timer control register fields
`define ASP_TB_EN          0
`define ASP_TB_SEL_HI      3
`define ASP_TB_SEL_LO      1
`define ASP_TB_IE          4
`define ASP_TB_CNT_HI      15
`define ASP_TB_CNT_LO      8

// Baud timer clock sources
`define ASP_SRC_SYS        3'h0
`define ASP_SRC_DIV4       3'h1
`define ASP_SRC_DIV12      3'h2
`define ASP_SRC_DIV48      3'h3
`define ASP_SRC_OSC8       3'h4
`define ASP_SRC_EXT        3'h5

// Prescaler terminal counts
`define ASP_DIV4_LAST      2'h3
`define ASP_DIV12_LAST     4'hB
`define ASP_DIV48_LAST     6'h2F
`define ASP_OSC8_LAST      3'h7

// Counter overflow value and frame lengths in bits
`define ASP_CNT_TOP        8'hFF
`define ASP_TX_BITS_8      4'hA
`define ASP_TX_BITS_9      4'hB
`define ASP_RX_LAST_8      4'h9
`define ASP_RX_LAST_9      4'hA
`define ASP_RX_DATA_LAST   4'h8
`define ASP_RX_NINTH       4'h9

// Reset values
`define ASP_CTRL_RST       8'h40
`define ASP_BYTE_RST       8'h00

`endif

/* asp_far_end.sv */
// Remote serial transceiver model on the far side of the line.
// Assumes its bit time in clocks equals the port's programmed rate.
`timescale 1ns/1ps
module asp_far_end #(parameter int BIT_CLKS = 16) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1; // Idle high

    // Send one frame LSB first; bits change just after an edge
    task automatic send(input logic [7:0] d, input bit nine, input logic b9, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask

    // Sample a frame at mid-bit; a wrong rate garbles the data
    task automatic recv(input bit nine, output logic [8:0] d, output logic stp);
        d = 9'h000;
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            d[i] = line_in;
        end
        repeat (BIT_CLKS) @(posedge clk);
        stp = line_in;
    endtask
endmodule // asp_far_end

/* asp_serial_port.v */
// Asynchronous serial port with auto-reload baud timer and APB registers.
// Assumes one 50 MHz clock, synchronous active-high reset, zero-wait APB.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "asp_consts.vh"

module asp_serial_port (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        serial_input_pin,
    input  wire        ext_osc_clk_in,
    input  wire        timer_external_input,
    output reg         serial_output_pin,
    output wire        serial_irq
);

    // Control and data state
    reg  [7:0]  ctrl_reg;
    reg  [7:0]  rx_buf_reg;
    reg  [7:0]  reload_reg;
    reg         tmr_en_reg;
    reg  [2:0]  tmr_sel_reg;
    reg         irq_en_reg;

    // Synchronisers for off-domain inputs
    reg  [1:0]  rx_sync_reg;
    reg  [1:0]  osc_sync_reg;
    reg  [1:0]  ext_sync_reg;
    reg         rx_prev_reg;
    reg         osc_prev_reg;
    reg         ext_prev_reg;

    // Baud timer prescalers and counters
    reg  [1:0]  div4_reg;
    reg  [3:0]  div12_reg;
    reg  [5:0]  div48_reg;
    reg  [2:0]  osc8_reg;
    reg  [7:0]  tx_cnt_reg;
    reg  [7:0]  rx_cnt_reg;
    reg         tx_half_reg;
    reg         rx_half_reg;

    // Transmitter state
    reg         tx_busy_reg;
    reg  [10:0] tx_shift_reg;
    reg  [3:0]  tx_count_reg;

    // Receiver state
    reg         rx_busy_reg;
    reg  [3:0]  rx_idx_reg;
    reg  [7:0]  rx_shift_reg;
    reg         rx_bit9_reg;

    // Decode, tick and frame-control nets
    wire        apb_setup;
    wire        apb_wr;
    wire        hit_ctrl;
    wire        hit_buf;
    wire        hit_reload;
    wire        hit_timer;
    wire        rx_s;
    wire        osc_rise;
    wire        ext_rise;
    reg         src_tick;
    wire        tmr_tick;
    wire        tx_ovf;
    wire        rx_ovf;
    wire        tx_bit_tick;
    wire        rx_sample;
    wire        start_det;
    wire        mode9;
    wire        tx_write;
    wire        ti_set;
    wire        ri_set;
    wire [3:0]  rx_last;
    wire        rx_final;
    wire        rx_accept;
    wire        rx_ninth;

    // APB decode; zero wait state, unmapped addresses flag an error
    assign apb_setup  = psel & ~penable;
    assign apb_wr     = psel & penable & pwrite;
    assign hit_ctrl   = (paddr == `ASP_ADDR_CTRL);
    assign hit_buf    = (paddr == `ASP_ADDR_BUF);
    assign hit_reload = (paddr == `ASP_ADDR_RELOAD);
    assign hit_timer  = (paddr == `ASP_ADDR_TIMER);
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~(hit_ctrl | hit_buf | hit_reload | hit_timer);

    // Read data captured in setup so it is stable in the access phase
    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata[7:0] <= ctrl_reg;
            end else if (hit_buf) begin
                prdata[7:0] <= rx_buf_reg;
            end else if (hit_reload) begin
                prdata[7:0] <= reload_reg;
            end else if (hit_timer) begin
                prdata[`ASP_TB_EN]                    <= tmr_en_reg;
                prdata[`ASP_TB_SEL_HI:`ASP_TB_SEL_LO] <= tmr_sel_reg;
                prdata[`ASP_TB_IE]                    <= irq_en_reg;
                prdata[`ASP_TB_CNT_HI:`ASP_TB_CNT_LO] <= tx_cnt_reg;
            end
        end
    end

    // Two flops per pin before any logic looks at it
    always @(posedge clk) begin
        if (rst) begin
            rx_sync_reg  <= 2'b11;
            osc_sync_reg <= 2'b00;
            ext_sync_reg <= 2'b00;
            rx_prev_reg  <= 1'b1;
            osc_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            rx_sync_reg  <= {rx_sync_reg[0], serial_input_pin};
            osc_sync_reg <= {osc_sync_reg[0], ext_osc_clk_in};
            ext_sync_reg <= {ext_sync_reg[0], timer_external_input};
            rx_prev_reg  <= rx_sync_reg[1];
            osc_prev_reg <= osc_sync_reg[1];
            ext_prev_reg <= ext_sync_reg[1];
        end
    end

    // Synchronised line and edges of the slow external clocks
    assign rx_s     = rx_sync_reg[1];
    assign osc_rise = osc_sync_reg[1] & ~osc_prev_reg;
    assign ext_rise = ext_sync_reg[1] & ~ext_prev_reg;

    // Free-running prescalers; external sources must be below clk/2
    always @(posedge clk) begin
        if (rst) begin
            div4_reg  <= 2'h0;
            div12_reg <= 4'h0;
            div48_reg <= 6'h00;
            osc8_reg  <= 3'h0;
        end else begin
            div4_reg  <= div4_reg + 2'h1;
            div12_reg <= (div12_reg == `ASP_DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
            div48_reg <= (div48_reg == `ASP_DIV48_LAST) ? 6'h00 : div48_reg + 6'h01;
            if (osc_rise) begin
                osc8_reg <= osc8_reg + 3'h1;
            end
        end
    end

    // Clock source select for the baud timer
    always @* begin
        case (tmr_sel_reg)
            `ASP_SRC_SYS:   src_tick = 1'b1;
            `ASP_SRC_DIV4:  src_tick = (div4_reg == `ASP_DIV4_LAST);
            `ASP_SRC_DIV12: src_tick = (div12_reg == `ASP_DIV12_LAST);
            `ASP_SRC_DIV48: src_tick = (div48_reg == `ASP_DIV48_LAST);
            `ASP_SRC_OSC8:  src_tick = osc_rise & (osc8_reg == `ASP_OSC8_LAST);
            `ASP_SRC_EXT:   src_tick = ext_rise;
            default:        src_tick = 1'b0;
        endcase
    end

    // Timer advances only while enabled
    assign tmr_tick = tmr_en_reg & src_tick;
    // Overflow every (256 - reload) timer clocks
    assign tx_ovf   = tmr_tick & (tx_cnt_reg == `ASP_CNT_TOP);
    assign rx_ovf   = tmr_tick & (rx_cnt_reg == `ASP_CNT_TOP);
    // Every second overflow is one bit time
    assign tx_bit_tick = tx_ovf & tx_half_reg;
    // Odd overflows after start reload land mid-bit
    assign rx_sample   = rx_ovf & ~rx_half_reg;

    // Frame length and start detection
    assign mode9     = ctrl_reg[`ASP_CB_MODE];
    // Falling edge of an idle-high line while enabled is a start
    assign start_det = ~rx_busy_reg & ctrl_reg[`ASP_CB_REN] & rx_prev_reg & ~rx_s;

    // Transmit counter: auto-reload from the reload byte
    always @(posedge clk) begin
        if (rst) begin
            tx_cnt_reg  <= `ASP_BYTE_RST;
            tx_half_reg <= 1'b0;
        end else if (tmr_tick) begin
            tx_cnt_reg <= tx_ovf ? reload_reg : tx_cnt_reg + 8'h01;
            if (tx_ovf) begin
                tx_half_reg <= ~tx_half_reg;
            end
        end
    end

    // Hidden receive counter, forced to reload on a start edge
    always @(posedge clk) begin
        if (rst) begin
            rx_cnt_reg  <= `ASP_BYTE_RST;
            rx_half_reg <= 1'b0;
        end else if (start_det) begin
            rx_cnt_reg  <= reload_reg;
            rx_half_reg <= 1'b0;
        end else if (tmr_tick) begin
            rx_cnt_reg <= rx_ovf ? reload_reg : rx_cnt_reg + 8'h01;
            if (rx_ovf) begin
                rx_half_reg <= ~rx_half_reg;
            end
        end
    end

    // Transmitter; writes while a frame is going out are dropped
    assign tx_write = apb_wr & hit_buf & ~tx_busy_reg;
    assign ti_set   = tx_busy_reg & tx_bit_tick &
                      (tx_count_reg == ((mode9 ? `ASP_TX_BITS_9 : `ASP_TX_BITS_8) - 4'h1));

    // One bit per bit tick; the stop bit stands a full bit time
    always @(posedge clk) begin
        if (rst) begin
            tx_busy_reg       <= 1'b0;
            tx_shift_reg      <= 11'h7FF;
            tx_count_reg      <= 4'h0;
            serial_output_pin <= 1'b1;
        end else if (tx_write) begin
            tx_busy_reg  <= 1'b1;
            tx_count_reg <= 4'h0;
            // Start, data LSB first, ninth or stop, stop
            if (mode9) begin
                tx_shift_reg <= {1'b1, ctrl_reg[`ASP_CB_TB8], pwdata[7:0], 1'b0};
            end else begin
                tx_shift_reg <= {1'b1, 1'b1, pwdata[7:0], 1'b0};
            end
        end else if (tx_busy_reg & tx_bit_tick) begin
            if (tx_count_reg == (mode9 ? `ASP_TX_BITS_9 : `ASP_TX_BITS_8)) begin
                tx_busy_reg       <= 1'b0;
                serial_output_pin <= 1'b1;
            end else begin
                serial_output_pin <= tx_shift_reg[0];
                tx_shift_reg      <= {1'b1, tx_shift_reg[10:1]};
                tx_count_reg      <= tx_count_reg + 4'h1;
            end
        end
    end

    // Receiver; runs alongside the transmitter
    assign rx_last   = mode9 ? `ASP_RX_LAST_9 : `ASP_RX_LAST_8;
    assign rx_final  = rx_busy_reg & rx_sample & (rx_idx_reg == rx_last);
    // In 8-bit mode the final sample is the stop bit itself; the stored
    // copy is only written at that same edge, so use the live sample
    assign rx_ninth  = mode9 ? rx_bit9_reg : rx_s;
    assign rx_accept = rx_final & ~ctrl_reg[`ASP_CB_RI] &
                       (~ctrl_reg[`ASP_CB_MCE] | rx_ninth);
    assign ri_set    = rx_accept;

    // Index 0 checks the start, then data, then ninth or stop
    always @(posedge clk) begin
        if (rst) begin
            rx_busy_reg  <= 1'b0;
            rx_idx_reg   <= 4'h0;
            rx_shift_reg <= `ASP_BYTE_RST;
            rx_bit9_reg  <= 1'b0;
        end else if (start_det) begin
            rx_busy_reg <= 1'b1;
            rx_idx_reg  <= 4'h0;
        end else if (rx_busy_reg & ~ctrl_reg[`ASP_CB_REN]) begin
            rx_busy_reg <= 1'b0;
        end else if (rx_busy_reg & rx_sample) begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0) begin
                // False start: line back high at mid start bit
                if (rx_s) begin
                    rx_busy_reg <= 1'b0;
                end
            end else if (rx_idx_reg <= `ASP_RX_DATA_LAST) begin
                rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
            end else if (rx_idx_reg == `ASP_RX_NINTH) begin
                rx_bit9_reg <= rx_s;
            end
            if (rx_final) begin
                rx_busy_reg <= 1'b0;
            end
        end
    end

    // Receive holding buffer, loaded only on accepted frames
    always @(posedge clk) begin
        if (rst) begin
            rx_buf_reg <= `ASP_BYTE_RST;
        end else if (rx_accept) begin
            rx_buf_reg <= rx_shift_reg;
        end
    end

    // Software registers; hardware set wins over a clear in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            ctrl_reg    <= `ASP_CTRL_RST;
            reload_reg  <= `ASP_BYTE_RST;
            tmr_en_reg  <= 1'b0;
            tmr_sel_reg <= `ASP_SRC_SYS;
            irq_en_reg  <= 1'b0;
        end else begin
            if (apb_wr & hit_ctrl) begin
                ctrl_reg[`ASP_CB_MODE] <= pwdata[`ASP_CB_MODE];
                ctrl_reg[`ASP_CB_MCE]  <= pwdata[`ASP_CB_MCE];
                ctrl_reg[`ASP_CB_REN]  <= pwdata[`ASP_CB_REN];
                ctrl_reg[`ASP_CB_TB8]  <= pwdata[`ASP_CB_TB8];
            end
            ctrl_reg[`ASP_CB_ONE] <= 1'b1;
            // Ninth-bit flag follows accepted frames, else software
            if (rx_accept) begin
                ctrl_reg[`ASP_CB_RB8] <= rx_ninth;
            end else if (apb_wr & hit_ctrl) begin
                ctrl_reg[`ASP_CB_RB8] <= pwdata[`ASP_CB_RB8];
            end
            // Done flags: only software clears them
            if (ti_set) begin
                ctrl_reg[`ASP_CB_TI] <= 1'b1;
            end else if (apb_wr & hit_ctrl) begin
                ctrl_reg[`ASP_CB_TI] <= pwdata[`ASP_CB_TI];
            end
            if (ri_set) begin
                ctrl_reg[`ASP_CB_RI] <= 1'b1;
            end else if (apb_wr & hit_ctrl) begin
                ctrl_reg[`ASP_CB_RI] <= pwdata[`ASP_CB_RI];
            end
            if (apb_wr & hit_reload) begin
                reload_reg <= pwdata[7:0];
            end
            if (apb_wr & hit_timer) begin
                tmr_en_reg  <= pwdata[`ASP_TB_EN];
                tmr_sel_reg <= pwdata[`ASP_TB_SEL_HI:`ASP_TB_SEL_LO];
                irq_en_reg  <= pwdata[`ASP_TB_IE];
            end
        end
    end

    // Level request while either done flag stands
    assign serial_irq = irq_en_reg & (ctrl_reg[`ASP_CB_TI] | ctrl_reg[`ASP_CB_RI]);

endmodule // asp_serial_port

/* asp_serial_port_assertions.sv */
// Checker for the serial port: APB answers, idle line, flag hold.
// Assumes binding to asp_serial_port, one clock, sync active-high reset.
`timescale 1ns/1ps
module asp_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        serial_output_pin,
    input wire logic        serial_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Access phase and the four mapped word offsets
    wire acc = psel & penable;
    wire hit = (paddr[11:4] == 8'h00) & (paddr[1:0] == 2'b00);

    property p_idle; $fell(rst) |-> serial_output_pin && !serial_irq; endproperty
    a_idle: assert property (p_idle) else $error("line not idle after reset");
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_err; acc && !hit |-> pslverr && (pwrite || prdata == 32'h0000_0000); endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; acc && hit |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_ctl; acc && !pwrite && paddr == 12'h000 |-> prdata[6] && prdata[31:8] == 24'h00_0000; endproperty
    a_ctl: assert property (p_ctl) else $error("control read malformed");
    property p_buf; acc && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 24'h00_0000; endproperty
    a_buf: assert property (p_buf) else $error("buffer read upper bits set");
    property p_irq_off; acc && pwrite && paddr == 12'h00C && !pwdata[4] |=> !serial_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("request while disabled");
    // Request only drops on a software write to control or interrupt enable
    property p_hold;
        serial_irq && !(acc && pwrite && (paddr == 12'h000 || paddr == 12'h00C)) |=> serial_irq;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped by hardware");
    property p_start; $fell(serial_output_pin) |-> !serial_output_pin [*2]; endproperty
    a_start: assert property (p_start) else $error("start bit too short");

    c_tx: cover property ($fell(serial_output_pin));
    c_irq: cover property ($rose(serial_irq));
    c_err: cover property (acc && pslverr);
endmodule // asp_chk

bind asp_serial_port asp_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .serial_output_pin(serial_output_pin), .serial_irq(serial_irq));

/* asp_serial_port_test.sv */
// Self-checking bench: APB master, far-end model and a receive model.
// Assumes 50 MHz clock; reload 8'hF8 on the system clock gives 16-clock bits.
`timescale 1ns/1ps
module asp_serial_port_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        ext_osc = 1'b0;
    logic        ext_in = 1'b0;
    wire         pready, pslverr, serial_irq, rx_line, tx_line;
    wire  [31:0] prdata;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          dd;
    logic [31:0] r;
    logic [8:0]  got;
    logic        gstp, slv, ren, filt;
    logic [7:0]  c0, exp_buf = 8'h00;
    logic        exp_rb8 = 1'b0;
    logic        exp_ri = 1'b0;
    int          ticks [8] = '{99, 24, 8, 2, 2, 9, 0, 0};

    asp_serial_port uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .serial_input_pin(rx_line), .ext_osc_clk_in(ext_osc), .timer_external_input(ext_in),
        .serial_output_pin(tx_line), .serial_irq(serial_irq));
    asp_far_end #(.BIT_CLKS(16)) far (.clk(clk), .line_in(tx_line), .line_out(rx_line));

    always #10 clk = ~clk;
    // Slow external clocks (6 and 10 cycles) and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ext_osc <= (cyc % 6) < 3;
        ext_in <= (cyc % 10) < 5;
        if (cyc == 40000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Control write; the model follows the software-written bits
    task automatic ctl(input logic [7:0] v);
        apb(1, 12'h000, {24'h0, v});
        {filt, ren, exp_rb8, exp_ri} = {v[5], v[4], v[2], v[0]};
    endtask

    // Frame in from the far end, then buffer and flags against the model
    task automatic rx_frame(input logic [7:0] d, input bit nine, input logic b9, input logic stp);
        far.send(d, nine, b9, stp);
        if (ren && !exp_ri && (!filt || (nine ? b9 : stp))) begin
            exp_buf = d;
            exp_rb8 = nine ? b9 : stp;
            exp_ri = 1'b1;
        end
        apb(0, 12'h004, 0);
        chk(r, {24'h0, exp_buf});
        apb(0, 12'h000, 0);
        chk({r[2], r[0]}, {exp_rb8, exp_ri});
    endtask

    // Frame out via the buffer, captured at the far end
    task automatic tx_frame(input logic [7:0] d, input bit nine, input logic tb8);
        fork
            far.recv(nine, got, gstp);
            apb(1, 12'h004, {24'h0, d});
        join
        chk({gstp, got}, {1'b1, nine & tb8, d});
    endtask

    initial begin
        void'($urandom(32'h1f36065f));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(0, 12'h000, 0);
        chk(r, 32'h0000_0040);
        apb(0, 12'h010, 0);
        chk({slv, r}, {1'b1, 32'h0000_0000});
        // Every timer source, counted over 99 cycles with reload 0
        apb(1, 12'h008, 0);
        for (int s = 0; s < 8; s++) begin
            apb(1, 12'h00C, s * 2 + 1);
            c0 = r[15:8];
            apb(0, 12'h00C, 0);
            c0 = r[15:8];
            repeat (96) @(posedge clk);
            apb(0, 12'h00C, 0);
            dd = 8'(r[15:8] - c0);
            chk(dd >= ticks[s] && dd <= ticks[s] + (s < 6), 1);
        end
        apb(1, 12'h008, 32'h0000_00F8);
        apb(1, 12'h00C, 32'h0000_0011);
        ctl(8'h10);
        tx_frame($urandom, 0, 0);
        apb(0, 12'h000, 0);
        chk({r[1], serial_irq}, 2'b11);
        ctl(8'h10);
        @(posedge clk);
        chk(serial_irq, 0);
        rx_frame($urandom, 0, 0, 1);
        rx_frame($urandom, 0, 0, 1);
        ctl(8'h30);
        rx_frame($urandom, 0, 0, 0);
        ctl(8'h00);
        rx_frame($urandom, 0, 0, 1);
        ctl(8'hB8);
        // Both directions at once in nine-bit mode
        fork
            tx_frame($urandom, 1, 1);
            rx_frame($urandom, 1, 0, 1);
        join
        rx_frame($urandom, 1, 1, 0);
        for (int i = 0; i < 3; i++) begin
            ctl(8'h90);
            tx_frame($urandom, 1, 0);
            rx_frame($urandom, 1, $urandom, 1);
        end
        wrap_up();
    end
endmodule // asp_serial_port_test
